// ==== logic/vsd_decode.sv ====
// VME slave address decode, control register and DSP space map
// How it works
// - Geo address on A20..A16, A23..A21 zero
// - Jumper byte matched against A31..A24
// - Slave only, A32 D32 with blocks
// - Only extended modifiers 09..0B and 0D..0F answered; acknowledge cycles answered with any modifier
// - Singles everywhere, blocks on memory only
// - Memory, control, triggers and reset mapped
// - Holes in window end in bus error
// - Control bits 10..0 RW, bit 11 flag
// - Interrupt level zero disables, default zero
// - Acknowledge cycle returns status/ID byte
// - Request on flag rising edge if enabled
// - Writes fire DSP interrupts or board reset
// - Memory halves mapped into DSP data space
// - Channel FIFOs decoded with aliases
// - Time tag read as two bytes
// - I/O registers decoded, aliased per 256
// - Setup wait and sample counts
// - Setup bit 8 picks channel mode
// - Setup bits 11..9 pick clock tap
// - Setup top bits show timing checks
// - Test bits make 50 ns pulses
`timescale 1ns/1ps
`default_nettype none
module vsd_decode
  import vsd_pkg::*;
(
  input wire logic clk, // 40 MHz board clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [4:0] geo_addr, // Slot geographic address (pin)
  input wire logic [7:0] jumper_addr, // Jumper-set upper address
  input wire logic as_n, // Address strobe (pin)
  input wire logic ds_n, // Data strobe (pin, both merged)
  input wire vsd_vme_req_s vme_req, // Address, modifier and direction
  input wire logic [31:0] vme_wdata, // Write data from backplane
  output logic [31:0] vme_rdata, // Read data to backplane
  output logic vme_data_oe, // Drive data lines
  output logic dtack_n, // Data acknowledge, active low
  output logic berr_n, // Bus error, active low
  output logic [7:1] irq_n, // Interrupt request lines, active low
  output logic mem_sel, // Shared memory select
  output logic [11:0] mem_addr, // Shared memory longword address
  output logic mem_we, // Shared memory write strobe
  output logic [15:0] dsp_mem_sel, // DSP memory byte-half select
  input wire logic dsp_busy_flag_output, // DSP busy flag (pin)
  output logic host_command_irq_a, // DSP interrupt A pulse
  output logic host_command_irq_b, // DSP interrupt B pulse
  output logic board_reset_n, // Whole board reset, active low
  input wire vsd_dsp_req_s dsp_req, // DSP local access
  output logic [15:0] dsp_rdata, // DSP read data
  input wire logic [31:0] ch_empty, // Channel FIFO empty flags
  input wire logic [31:0] ch_full, // Channel FIFO full flags
  input wire logic [15:0] fifo_data, // Selected FIFO word
  output logic [31:0] data_fifo_re, // Data FIFO read enables
  output logic [31:0] tag_fifo_re, // Time tag FIFO read enables
  output logic [31:0] ch_enable, // Channel enables
  output logic [31:0] test_pulse, // Channel test pulses
  output logic ch_reset, // Reset all channels pulse
  output logic [15:0] acquisition_setup_bits, // Setup register image
  input wire logic [1:0] timing_check, // Setup/hold check inputs
  input wire logic [1:0] setup_spare_in, // Unused input bits 13..12
  output logic [15:0] time_captured // Captured time value
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [2:0] as_sync_reg, ds_sync_reg, flag_sync_reg;
  logic as_act, ds_act, flag_lvl, flag_prev_reg;
  // Three stages, assertion counts when stages two and three agree, release as soon as either shows it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      as_sync_reg <= 3'h7;
      ds_sync_reg <= 3'h7;
      flag_sync_reg <= 3'h0;
    end
    else
    begin
      as_sync_reg <= {as_sync_reg[1:0], as_n};
      ds_sync_reg <= {ds_sync_reg[1:0], ds_n};
      flag_sync_reg <= {flag_sync_reg[1:0], dsp_busy_flag_output};
    end
  end
  assign as_act = !as_sync_reg[1] && !as_sync_reg[2];
  assign ds_act = !ds_sync_reg[1] && !ds_sync_reg[2];
  assign flag_lvl = flag_sync_reg[1] && flag_sync_reg[2];

  // ************************************************************
  // Board selection
  // ************************************************************
  function automatic logic am_ok(input logic [5:0] am);
    am_ok = (am == VSD_AM_09) || (am == VSD_AM_0A) || (am == VSD_AM_0B) ||
      (am == VSD_AM_0D) || (am == VSD_AM_0E) || (am == VSD_AM_0F);
  endfunction
  logic board_hit, is_block, mem_hit, reg_hit, iack_hit;
  logic [10:0] ctrl_reg; // Status/ID and level; flag bit is read live
  logic irq_pend_reg; // Bus interrupt waiting for acknowledge
  logic [15:0] ofs;
  assign ofs = vme_req.addr[15:0];
  // Block modifiers are 0B and 0F
  assign is_block = (vme_req.am == VSD_AM_0B) || (vme_req.am == VSD_AM_0F);
  // geographic compare, upper middle bits zero
  // only longword, aligned cycles selected; checked here
  assign board_hit = (vme_req.addr[20:16] == geo_addr) && (vme_req.addr[23:21] == 3'h0)
    && (vme_req.addr[31:24] == jumper_addr) && am_ok(vme_req.am)
    && !vme_req.lword_n && (vme_req.addr[1:0] == 2'h0) && vme_req.iack_n;
  assign mem_hit = (ofs <= VSD_OFS_MEM_LAST);
  assign reg_hit = (ofs == VSD_OFS_IRQ_CTRL) || (ofs == VSD_OFS_DSP_IRQ_A) ||
    (ofs == VSD_OFS_DSP_IRQ_B) || (ofs == VSD_OFS_SOFT_RST);
  assign iack_hit = !vme_req.iack_n && (ctrl_reg[10:8] != VSD_IRQ_LEVEL_OFF)
    && (vme_req.addr[3:1] == ctrl_reg[10:8]) && irq_pend_reg;

  // ************************************************************
  // Cycle state machine
  // ************************************************************
  vsd_state_e state_reg;
  logic take;
  assign take = (state_reg == VSD_IDLE) && as_act && ds_act;
  // slave only: answers, never requests the bus
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_reg <= VSD_IDLE;
    else
      unique case (state_reg)
        VSD_IDLE:
          if (take && iack_hit)
            state_reg <= VSD_ACK;
          else if (take && board_hit)
          begin
            if (mem_hit || (reg_hit && !is_block))
              state_reg <= VSD_ACK;
            else
              state_reg <= VSD_BERR;
          end
        // Hold answer until strobe released
        VSD_ACK, VSD_BERR:
          if (!ds_act)
            state_reg <= VSD_WAIT;
        // Pipelined: next cycle may start while address strobe held
        VSD_WAIT:
          state_reg <= VSD_IDLE;
      endcase
  end
  assign dtack_n = !(state_reg == VSD_ACK);
  assign berr_n = !(state_reg == VSD_BERR);

  // Access strobes taken on entry
  logic wr_take;
  assign wr_take = take && board_hit && !vme_req.write_n && !is_block && reg_hit;
  // Read data latched at take
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      vme_rdata <= 32'h0000_0000;
    else if (take && iack_hit)
      vme_rdata <= {24'h00_0000, ctrl_reg[7:0]};
    else if (take && board_hit && (ofs == VSD_OFS_IRQ_CTRL))
      vme_rdata <= {20'h0_0000, flag_lvl, ctrl_reg};
    else if (take)
      vme_rdata <= 32'h0000_0000;
  end
  // Memory read data comes from the memory itself
  assign vme_data_oe = (state_reg == VSD_ACK) && vme_req.write_n && !(mem_sel);
  assign mem_sel = (state_reg == VSD_ACK) && vme_req.iack_n && mem_hit;
  assign mem_addr = ofs[13:2];
  assign mem_we = mem_sel && !vme_req.write_n;

  // ************************************************************
  // Status/control register and bus interrupt
  // ************************************************************
  // low bits read/write
  always_ff @(posedge clk)
  begin
    // Soft reset clears registers; cycle logic is spared so that write can finish
    if (!rst_n || !board_reset_n)
      ctrl_reg <= VSD_IRQ_CTRL_RESET;
    else if (wr_take && (ofs == VSD_OFS_IRQ_CTRL))
      ctrl_reg <= vme_wdata[VSD_IRQ_RW_BITS-1:0];
  end
  // rising edge, nonzero level; set wins over acknowledge
  always_ff @(posedge clk)
  begin
    if (!rst_n || !board_reset_n)
    begin
      flag_prev_reg <= 1'b0;
      irq_pend_reg <= 1'b0;
    end
    else
    begin
      flag_prev_reg <= flag_lvl;
      if (flag_lvl && !flag_prev_reg && (ctrl_reg[10:8] != VSD_IRQ_LEVEL_OFF))
        irq_pend_reg <= 1'b1;
      else if ((take && iack_hit) || (ctrl_reg[10:8] == VSD_IRQ_LEVEL_OFF))
        irq_pend_reg <= 1'b0;
    end
  end
  genvar gl;
  generate
    for (gl = 1; gl < 8; gl++)
    begin : g_irq
      assign irq_n[gl] = !(irq_pend_reg && (ctrl_reg[10:8] == 3'(gl)));
    end
  endgenerate

  // ************************************************************
  // Command triggers
  // ************************************************************
  // write-triggered pulses, data ignored
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      host_command_irq_a <= 1'b0;
      host_command_irq_b <= 1'b0;
      board_reset_n <= 1'b1;
    end
    else
    begin
      host_command_irq_a <= wr_take && (ofs == VSD_OFS_DSP_IRQ_A);
      host_command_irq_b <= wr_take && (ofs == VSD_OFS_DSP_IRQ_B);
      board_reset_n <= !(wr_take && (ofs == VSD_OFS_SOFT_RST));
    end
  end

  // ************************************************************
  // DSP data space
  // ************************************************************
  logic [3:0] ds_top;
  assign ds_top = dsp_req.addr[15:12];
  // memory halves: one-hot of nibble window
  // Only nibbles 4..7 are memory; other windows must not select a half
  assign dsp_mem_sel = dsp_req.data_sel && (dsp_req.addr[11:0] <= VSD_DS_MEM_SPAN[11:0])
    && (ds_top >= VSD_DS_MEM_LO0) && (ds_top <= VSD_DS_MEM_HI1)
    ? (16'h0001 << ds_top) : 16'h0000;
  // FIFO decode with aliases across the 4K block
  logic fifo_win;
  assign fifo_win = dsp_req.data_sel && dsp_req.rd && (ds_top == VSD_DS_FIFO);
  assign data_fifo_re = (fifo_win && !dsp_req.addr[5]) ? (32'h0000_0001 << dsp_req.addr[4:0])
    : 32'h0000_0000;
  // tag byte order tracked per read, upper FIFO advance on second
  logic tag_half_reg;
  always_ff @(posedge clk)
  begin
    if (!rst_n || !board_reset_n)
      tag_half_reg <= 1'b0;
    else if (fifo_win && dsp_req.addr[5])
      tag_half_reg <= !tag_half_reg;
  end
  assign tag_fifo_re = (fifo_win && dsp_req.addr[5] && tag_half_reg)
    ? (32'h0000_0001 << dsp_req.addr[4:0]) : 32'h0000_0000;

  // ************************************************************
  // DSP I/O registers
  // ************************************************************
  logic [15:0] free_time_reg, setup_reg, test_cnt_reg;
  logic io_wr;
  logic [7:0] io_idx;
  // low byte decode, aliased every 256; up to 0x0FFF for writes, throughout for reads
  assign io_idx = dsp_req.addr[7:0];
  assign io_wr = dsp_req.io_sel && dsp_req.wr && (dsp_req.addr[15:12] == 4'h0);
  always_ff @(posedge clk)
  begin
    if (!rst_n || !board_reset_n)
    begin
      ch_enable <= 32'h0000_0000;
      time_captured <= 16'h0000;
      setup_reg <= 16'h0000;
      ch_reset <= 1'b0;
    end
    else
    begin
      ch_reset <= io_wr && (io_idx == VSD_IO_CH_RST);
      if (io_wr && (io_idx == VSD_IO_EN_LO))
        ch_enable[15:0] <= dsp_req.wdata;
      if (io_wr && (io_idx == VSD_IO_EN_HI))
        ch_enable[31:16] <= dsp_req.wdata;
      if (io_wr && (io_idx == VSD_IO_TIME_CAP))
        time_captured <= dsp_req.wdata;
      else if (io_wr && (io_idx == VSD_IO_CH_RST))
        time_captured <= free_time_reg;
      // wait and sample counts, mode, tap
      if (io_wr && (io_idx == VSD_IO_SETUP))
        setup_reg <= {4'h0, dsp_req.wdata[11:0]};
    end
  end
  // Free-running time counter, writable
  always_ff @(posedge clk)
  begin
    if (!rst_n || !board_reset_n)
      free_time_reg <= 16'h0000;
    else if (io_wr && (io_idx == VSD_IO_TIME_FREE))
      free_time_reg <= dsp_req.wdata;
    else
      free_time_reg <= free_time_reg + 16'h0001;
  end
  assign acquisition_setup_bits = {timing_check, setup_spare_in, setup_reg[11:0]};
  // 50 ns pulse per set bit
  logic [31:0] test_pat_reg;
  always_ff @(posedge clk)
  begin
    if (!rst_n || !board_reset_n)
    begin
      test_pat_reg <= 32'h0000_0000;
      test_cnt_reg <= 16'h0000;
    end
    else if (io_wr && (io_idx == VSD_IO_TEST_LO || io_idx == VSD_IO_TEST_HI))
    begin
      test_pat_reg <= (io_idx == VSD_IO_TEST_LO) ? {16'h0000, dsp_req.wdata}
        : {dsp_req.wdata, 16'h0000};
      test_cnt_reg <= 16'(VSD_TEST_CYC);
    end
    else if (test_cnt_reg != 16'h0000)
      test_cnt_reg <= test_cnt_reg - 16'h0001;
  end
  assign test_pulse = (test_cnt_reg != 16'h0000) ? test_pat_reg : 32'h0000_0000;
  // I/O and FIFO read mux; time tag upper byte zero
  always_comb
  begin
    dsp_rdata = 16'h0000;
    if (fifo_win && dsp_req.addr[5])
      dsp_rdata = {8'h00, tag_half_reg ? fifo_data[15:8] : fifo_data[7:0]};
    else if (fifo_win)
      dsp_rdata = fifo_data;
    else if (dsp_req.io_sel)
      unique case (io_idx)
        VSD_IO_EMPTY_LO: dsp_rdata = ch_empty[15:0];
        VSD_IO_EMPTY_HI: dsp_rdata = ch_empty[31:16];
        VSD_IO_FULL_LO: dsp_rdata = ch_full[15:0];
        VSD_IO_FULL_HI: dsp_rdata = ch_full[31:16];
        VSD_IO_EN_LO: dsp_rdata = ch_enable[15:0];
        VSD_IO_EN_HI: dsp_rdata = ch_enable[31:16];
        VSD_IO_TIME_FREE: dsp_rdata = free_time_reg;
        VSD_IO_TIME_CAP: dsp_rdata = time_captured;
        VSD_IO_SETUP: dsp_rdata = acquisition_setup_bits;
        default: dsp_rdata = 16'h0000;
      endcase
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  a_no_ack_unsel: assert property (@(posedge clk) disable iff (!rst_n)
    (take && !board_hit && !iack_hit) |=> dtack_n && berr_n)
    else $error("acknowledged an unselected cycle");
  a_hole_berr: assert property (@(posedge clk) disable iff (!rst_n)
    (take && board_hit && !iack_hit && !mem_hit && !reg_hit) |=> !berr_n)
    else $error("hole not bus errored");
  a_irq_off: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_reg[10:8] == VSD_IRQ_LEVEL_OFF) |=> !irq_pend_reg && (irq_n == 7'h7F))
    else $error("interrupt while disabled");
  a_irq_a_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_take && ofs == VSD_OFS_DSP_IRQ_A) |=> host_command_irq_a ##1 !host_command_irq_a)
    else $error("dsp interrupt a pulse wrong");
  a_soft_reset: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_take && ofs == VSD_OFS_SOFT_RST) |=> !board_reset_n)
    else $error("soft reset missing");
  a_flag_read: assert property (@(posedge clk) disable iff (!rst_n)
    (take && board_hit && !iack_hit && ofs == VSD_OFS_IRQ_CTRL) |=>
    vme_rdata[VSD_IRQ_FLAG_BIT] == $past(flag_lvl))
    else $error("flag bit not shown");
  a_test_width: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(test_cnt_reg != 16'h0000) |-> (test_cnt_reg != 16'h0000) [*2] ##1
    (test_cnt_reg == 16'h0000))
    else $error("test pulse width wrong");
  a_geo_match: assert property (@(posedge clk) disable iff (!rst_n)
    (take && vme_req.addr[20:16] != geo_addr && vme_req.iack_n) |=> dtack_n && berr_n)
    else $error("geo mismatch answered");
endmodule
`default_nettype wire

// ==== logic/vsd_pkg.sv ====
// Package: constants and carrier types for the VME slave decode block
package vsd_pkg;
  // Bus side offsets within the board window
  localparam logic [15:0] VSD_OFS_MEM_LAST = 16'h3FFF;
  localparam logic [15:0] VSD_OFS_IRQ_CTRL = 16'h8000;
  localparam logic [15:0] VSD_OFS_DSP_IRQ_A = 16'h8004;
  localparam logic [15:0] VSD_OFS_DSP_IRQ_B = 16'h8008;
  localparam logic [15:0] VSD_OFS_SOFT_RST = 16'h800C;
  // Accepted address modifiers
  localparam logic [5:0] VSD_AM_09 = 6'h09;
  localparam logic [5:0] VSD_AM_0A = 6'h0A;
  localparam logic [5:0] VSD_AM_0B = 6'h0B;
  localparam logic [5:0] VSD_AM_0D = 6'h0D;
  localparam logic [5:0] VSD_AM_0E = 6'h0E;
  localparam logic [5:0] VSD_AM_0F = 6'h0F;
  // Status/control register layout
  localparam int VSD_IRQ_RW_BITS = 11;
  localparam int VSD_IRQ_FLAG_BIT = 11;
  localparam logic [10:0] VSD_IRQ_CTRL_RESET = 11'h000;
  localparam logic [2:0] VSD_IRQ_LEVEL_OFF = 3'h0;
  // DSP data space windows (upper address nibble)
  localparam logic [3:0] VSD_DS_MEM_LO0 = 4'h4;
  localparam logic [3:0] VSD_DS_MEM_HI0 = 4'h5;
  localparam logic [3:0] VSD_DS_MEM_LO1 = 4'h6;
  localparam logic [3:0] VSD_DS_MEM_HI1 = 4'h7;
  localparam logic [3:0] VSD_DS_FIFO = 4'h8;
  localparam logic [15:0] VSD_DS_MEM_SPAN = 16'h07FF;
  // DSP I/O register indices (low byte of address)
  localparam logic [7:0] VSD_IO_EMPTY_LO = 8'h50;
  localparam logic [7:0] VSD_IO_EMPTY_HI = 8'h51;
  localparam logic [7:0] VSD_IO_FULL_LO = 8'h52;
  localparam logic [7:0] VSD_IO_FULL_HI = 8'h53;
  localparam logic [7:0] VSD_IO_EN_LO = 8'h54;
  localparam logic [7:0] VSD_IO_EN_HI = 8'h55;
  localparam logic [7:0] VSD_IO_TIME_FREE = 8'h56;
  localparam logic [7:0] VSD_IO_TIME_CAP = 8'h57;
  localparam logic [7:0] VSD_IO_SETUP = 8'h58;
  localparam logic [7:0] VSD_IO_TEST_LO = 8'h59;
  localparam logic [7:0] VSD_IO_TEST_HI = 8'h5A;
  localparam logic [7:0] VSD_IO_CH_RST = 8'h5B;
  // Test pulse width
  localparam int VSD_CLK_MHZ = 40;
  localparam int VSD_TEST_PULSE_NS = 50;
  localparam int VSD_TEST_CYC = (VSD_TEST_PULSE_NS * VSD_CLK_MHZ) / 1000;
  // Backplane cycle request
  typedef struct packed {
    logic [31:0] addr;
    logic [5:0] am;
    logic lword_n;
    logic write_n;
    logic iack_n;
  } vsd_vme_req_s;
  // DSP local strobe group
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic data_sel;
    logic io_sel;
    logic rd;
    logic wr;
  } vsd_dsp_req_s;
  typedef enum logic [1:0] {
    VSD_IDLE = 2'b00,
    VSD_ACK = 2'b01,
    VSD_BERR = 2'b10,
    VSD_WAIT = 2'b11
  } vsd_state_e;
endpackage

// ==== dv/vsd_vme_master.sv ====
// Crate controller model issuing backplane cycles
`timescale 1ns/1ps
`default_nettype none
module vsd_vme_master
  import vsd_pkg::*;
(
  input wire logic clk, // Board clock
  input wire logic dtack_n, // Slave acknowledge
  input wire logic berr_n, // Slave bus error
  input wire logic [31:0] vme_rdata, // Slave read data
  output logic as_n = 1'b1, // Address strobe
  output logic ds_n = 1'b1, // Data strobe
  output vsd_vme_req_s vme_req = '1, // Address group
  output logic [31:0] vme_wdata = '0 // Write data
);
  // ****************
  // Cycle task
  // ****************
  // One cycle; resp 0 none, 1 acknowledge, 2 bus error
  task automatic cycle(input logic [31:0] a, input logic [5:0] am, input logic wr,
    input logic lw_n, input logic iack_n, input logic [31:0] wd, input int slow,
    output logic [1:0] resp, output logic [31:0] rd);
    int n;
    @(posedge clk);
    // caller sets A23..A21 low and longword alignment
    vme_req <= '{addr: a, am: am, lword_n: lw_n, write_n: !wr, iack_n: iack_n};
    vme_wdata <= wd;
    as_n <= 1'b0;
    // A slow master holds the data strobe back
    repeat (slow) @(posedge clk);
    ds_n <= 1'b0;
    for (n = 0; n < 20 && dtack_n && berr_n; n++)
      @(posedge clk);
    resp = !dtack_n ? 2'd1 : (!berr_n ? 2'd2 : 2'd0);
    rd = vme_rdata;
    as_n <= 1'b1;
    ds_n <= 1'b1;
    // Released lines stop showing the old value
    vme_wdata <= ~wd;
    vme_req.addr <= ~a;
    for (n = 0; n < 20 && !(dtack_n && berr_n); n++)
      @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== dv/vme_slave_decode_and_dsp_map_test.sv ====
// Self-checking bench for the VME slave decode block
`timescale 1ns/1ps
`default_nettype none
module vme_slave_decode_and_dsp_map_test
  import vsd_pkg::*;
;
  // ****************
  // Signals
  // ****************
  localparam logic [31:0] BASE = 32'hA50B_0000; // Jumpers A5, slot 0B
  logic clk = 1'b0; // Board clock
  logic rst_n = 1'b0; // Reset, active low
  logic as_n, ds_n, vme_data_oe, dtack_n, berr_n, mem_sel, mem_we; // Backplane
  vsd_vme_req_s vme_req; // Cycle request
  logic [31:0] vme_wdata, vme_rdata, data_fifo_re, tag_fifo_re, ch_enable, test_pulse;
  logic [7:1] irq_n; // Interrupt lines
  logic [11:0] mem_addr; // Memory address
  logic [15:0] dsp_mem_sel, dsp_rdata, acquisition_setup_bits, time_captured;
  logic [15:0] fifo_data = 16'hC3A7; // FIFO word
  logic dsp_busy_flag_output = 1'b0; // DSP busy flag
  logic host_command_irq_a, host_command_irq_b, board_reset_n, ch_reset; // Pulses
  vsd_dsp_req_s dsp_req = '0; // DSP access
  logic [31:0] ch_empty = 32'hA5A5_5A5A, ch_full = 32'h0F0F_F0F0; // FIFO flags
  logic [1:0] timing_check = 2'b10, setup_spare_in = 2'b01; // Setup inputs
  int fail_count = 0; // Mismatches
  int n_checks = 0; // Comparisons
  int n_a = 0, n_b = 0, n_rst = 0, n_crst = 0, n_tp = 0; // Event counts
  logic [31:0] tp_seen = '0; // Last test pattern
  logic [11:0] mem_seen = '0; // Last written memory address
  logic [1:0] resp; // Last answer
  logic [31:0] rd; // Last read data
  logic oe_seen = 1'b0; // Data drive during last answer
  always #12.5 clk = ~clk;
  vsd_decode u_dut (.clk, .rst_n, .geo_addr(5'h0B), .jumper_addr(8'hA5), .as_n, .ds_n,
    .vme_req, .vme_wdata, .vme_rdata, .vme_data_oe, .dtack_n, .berr_n, .irq_n, .mem_sel,
    .mem_addr, .mem_we, .dsp_mem_sel, .dsp_busy_flag_output, .host_command_irq_a,
    .host_command_irq_b, .board_reset_n, .dsp_req, .dsp_rdata, .ch_empty, .ch_full,
    .fifo_data, .data_fifo_re, .tag_fifo_re, .ch_enable, .test_pulse, .ch_reset,
    .acquisition_setup_bits, .timing_check, .setup_spare_in, .time_captured);
  vsd_vme_master u_m (.clk, .dtack_n, .berr_n, .vme_rdata, .as_n, .ds_n, .vme_req,
    .vme_wdata);
  // Counts pulses; deltas avoid racing the counters
  always @(posedge clk)
  begin
    n_a <= n_a + host_command_irq_a;
    n_b <= n_b + host_command_irq_b;
    n_rst <= n_rst + !board_reset_n;
    n_crst <= n_crst + ch_reset;
    n_tp <= n_tp + (test_pulse != 32'h0);
    if (test_pulse != 32'h0)
      tp_seen <= test_pulse;
    if (mem_sel && mem_we)
      mem_seen <= mem_addr;
    if (!dtack_n)
      oe_seen <= vme_data_oe;
  end
  // ****************
  // Tasks
  // ****************
  task automatic final_report();
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic acc(input logic [31:0] a, input logic [5:0] am, input logic wr,
    input logic [31:0] wd, input logic [1:0] exp);
    u_m.cycle(a, am, wr, 1'b0, 1'b1, wd, 0, resp, rd);
    check("vme answer", 32'(exp), 32'(resp));
  endtask
  // DSP strobe for one cycle; reads are sampled once settled
  task automatic dsp(input logic io, input logic wr, input logic [15:0] a,
    input logic [15:0] wd);
    @(posedge clk);
    dsp_req <= '{addr: a, wdata: wd, data_sel: !io, io_sel: io, rd: !wr, wr: wr};
    #1;
  endtask
  task automatic t_ctrl();
    acc(BASE | 32'h8000, VSD_AM_09, 1'b0, 32'h0, 2'd1);
    check("ctrl reset", 32'h0, 32'(rd[11:0]));
    check("data drive read", 32'h1, 32'(oe_seen));
    check("irq idle", 32'h7F, 32'(irq_n));
    acc(BASE | 32'h8000, VSD_AM_0D, 1'b1, 32'hFFFF_F2A5, 2'd1);
    dsp_busy_flag_output <= 1'b1;
    for (int i = 0; i < 10 && irq_n === 7'h7F; i++)
      @(posedge clk);
    check("irq level", 32'h7D, 32'(irq_n));
    acc(BASE | 32'h8000, VSD_AM_0E, 1'b0, 32'h0, 2'd1);
    check("ctrl flag", 32'hAA5, 32'(rd[11:0]));
    u_m.cycle(32'h0000_0004, VSD_AM_09, 1'b0, 1'b0, 1'b0, 32'h0, 0, resp, rd);
    check("iack answer", 32'h1, 32'(resp));
    check("iack id", 32'hA5, 32'(rd[7:0]));
    check("irq cleared", 32'h7F, 32'(irq_n));
    dsp_busy_flag_output <= 1'b0;
    acc(BASE | 32'h8000, VSD_AM_09, 1'b1, 32'h0000_00A5, 2'd1);
    dsp_busy_flag_output <= 1'b1;
    repeat (10) @(posedge clk);
    check("irq off", 32'h7F, 32'(irq_n));
    acc(BASE | 32'h8000, VSD_AM_09, 1'b1, 32'h0000_02A5, 2'd1);
    check("no edge", 32'h7F, 32'(irq_n));
    dsp_busy_flag_output <= 1'b0;
  endtask
  task automatic t_map();
    logic [5:0] ams [6] = '{VSD_AM_09, VSD_AM_0A, VSD_AM_0B, VSD_AM_0D, VSD_AM_0E, VSD_AM_0F};
    logic [15:0] holes [4] = '{16'h4000, 16'h7FFC, 16'h8010, 16'hFFFC};
    foreach (ams[i])
    begin
      acc(BASE | (32'h3FFC - 32'(i) * 4), ams[i], 1'b1, 32'h1234_5678, 2'd1);
      check("mem address", 32'hFFF - 32'(i), 32'(mem_seen));
    end
    check("data drive write", 32'h0, 32'(oe_seen));
    foreach (holes[i])
      acc(BASE | 32'(holes[i]), VSD_AM_09, 1'b0, 32'h0, 2'd2);
    acc(BASE | 32'h8000, VSD_AM_0B, 1'b0, 32'h0, 2'd2);
  endtask
  task automatic t_refuse();
    logic [31:0] bad [8] = '{BASE ^ 32'h0100_0000, BASE ^ 32'h0001_0000, BASE | 32'h0020_0000,
      BASE | 32'h0080_0000, BASE | 32'h0000_8002, BASE | 32'h8000, BASE | 32'h8000,
      BASE | 32'h8000};
    logic [5:0] am [8] = '{6'h09, 6'h09, 6'h09, 6'h09, 6'h09, 6'h39, 6'h2D, 6'h09};
    foreach (bad[i])
    begin
      u_m.cycle(bad[i], am[i], 1'b0, i == 7, 1'b1, 32'h0, 0, resp, rd);
      check("refused", 32'h0, 32'(resp));
    end
  endtask
  task automatic t_trig();
    int a0 = n_a;
    int b0 = n_b;
    int r0 = n_rst;
    acc(BASE | 32'h8004, VSD_AM_09, 1'b1, 32'h0, 2'd1);
    check("irq a", 32'h1, 32'(n_a - a0));
    u_m.cycle(BASE | 32'h8008, VSD_AM_0D, 1'b1, 1'b0, 1'b1, 32'hFFFF_FFFF, 3, resp, rd);
    check("irq b answer", 32'h1, 32'(resp));
    check("irq b", 32'h1, 32'(n_b - b0));
    check("irq a once", 32'h1, 32'(n_a - a0));
    acc(BASE | 32'h800C, VSD_AM_09, 1'b1, 32'h0, 2'd1);
    check("board reset", 32'h1, 32'(n_rst - r0));
    repeat (4) @(posedge clk);
    acc(BASE | 32'h8000, VSD_AM_09, 1'b0, 32'h0, 2'd1);
    check("ctrl cleared", 32'h0, 32'(rd[10:0]));
  endtask
  task automatic t_dsp();
    logic [15:0] fl [4] = '{16'hC3C3, 16'h3C3C, 16'hF0F0, 16'h0F0F};
    int p0 = n_tp;
    int c0 = n_crst;
    dsp(1'b1, 1'b1, 16'h0354, 16'hBEEF);
    dsp(1'b1, 1'b1, 16'h0F55, 16'h1234);
    dsp(1'b1, 1'b0, 16'h0054, 16'h0000);
    check("enable read", 32'hBEEF, 32'(dsp_rdata));
    check("enable out", 32'h1234_BEEF, ch_enable);
    dsp(1'b1, 1'b1, 16'h0058, 16'hFFFF);
    dsp(1'b1, 1'b0, 16'h0758, 16'h0000);
    check("setup read", 32'h9FFF, 32'(dsp_rdata));
    check("setup out", 32'hFFF, 32'(acquisition_setup_bits[11:0]));
    ch_empty <= 32'h3C3C_C3C3;
    foreach (fl[i])
    begin
      dsp(1'b1, 1'b0, 16'h0050 + 16'(i), 16'h0000);
      check("flags", 32'(fl[i]), 32'(dsp_rdata));
    end
    dsp(1'b1, 1'b1, 16'h0159, 16'h8001);
    dsp(1'b1, 1'b1, 16'h0056, 16'h1000);
    dsp(1'b1, 1'b1, 16'h005B, 16'h0000);
    dsp(1'b0, 1'b0, 16'h0000, 16'h0000);
    repeat (4) @(posedge clk);
    check("pulse width", 32'(VSD_TEST_CYC), 32'(n_tp - p0));
    check("pulse map", 32'h0000_8001, tp_seen);
    check("channel reset", 32'h1, 32'(n_crst - c0));
    check("time capture", 32'h1000, 32'(time_captured));
    dsp(1'b1, 1'b1, 16'h005A, 16'h4000);
    dsp(1'b0, 1'b0, 16'h0000, 16'h0000);
    repeat (4) @(posedge clk);
    check("pulse map high", 32'h4000_0000, tp_seen);
    for (int i = 0; i < 4; i++)
    begin
      dsp(1'b0, 1'b0, {4'h4 + 4'(i), 12'h123}, 16'h0000);
      check("mem half", 32'h10 << i, 32'(dsp_mem_sel));
    end
    fifo_data <= 16'h5AC3;
    dsp(1'b0, 1'b0, 16'h8805, 16'h0000);
    check("data fifo", 32'h5AC3, 32'(dsp_rdata));
    check("data enable", 32'h20, data_fifo_re);
    dsp(1'b0, 1'b0, 16'h8F21, 16'h0000);
    check("tag low", 32'hC3, 32'(dsp_rdata));
    check("tag wait", 32'h0, tag_fifo_re);
    dsp(1'b0, 1'b0, 16'h8F21, 16'h0000);
    check("tag high", 32'h5A, 32'(dsp_rdata));
    check("tag enable", 32'h2, tag_fifo_re);
    dsp(1'b0, 1'b0, 16'h0000, 16'h0000);
    check("mem half off", 32'h0, 32'(dsp_mem_sel));
  endtask
  // ****************
  // Run
  // ****************
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_ctrl();
    t_map();
    t_refuse();
    t_trig();
    t_dsp();
    final_report();
  end
  // Watchdog: the run needs some 500 cycles
  initial
  begin
    #200_000;
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire
